/* File: hw/cbg_top.sv */
// Core clock burst gating with AXI4-Lite register access
`timescale 1ns/1ps
`default_nettype none
`include "cbg_map.svh"

module cbg_top
    import cbg_pkg::*;
(
    input wire logic mclk, // System master clock, 100 MHz
    input wire logic rst_n, // Synchronous reset, active low
    input wire logic slow_32k_clock, // 32 kHz pin, asynchronous
    input wire logic wake_event, // Wake-up or any interrupt, masked or not
    input wire logic core_bus_grant, // Core gives up the bus
    input wire logic dma_busy, // DMA access in progress
    output logic core_gated_clock_en, // Enable for the core clock gate
    output logic core_bus_req, // Bus request to the core
    output logic dma_bus_grant, // Bus grant to the DMA controller
    input wire logic [3:0] s_axi_awaddr, // Write address
    input wire logic s_axi_awvalid, // Write address valid
    output logic s_axi_awready, // Write address ready
    input wire logic [31:0] s_axi_wdata, // Write data
    input wire logic [3:0] s_axi_wstrb, // Write strobes
    input wire logic s_axi_wvalid, // Write data valid
    output logic s_axi_wready, // Write data ready
    output logic [1:0] s_axi_bresp, // Write response
    output logic s_axi_bvalid, // Write response valid
    input wire logic s_axi_bready, // Write response ready
    input wire logic [3:0] s_axi_araddr, // Read address
    input wire logic s_axi_arvalid, // Read address valid
    output logic s_axi_arready, // Read address ready
    output logic [31:0] s_axi_rdata, // Read data
    output logic [1:0] s_axi_rresp, // Read response
    output logic s_axi_rvalid, // Read data valid
    input wire logic s_axi_rready // Read data ready
);

    // -------------------------------------------------------------------------
    // Declarations
    // -------------------------------------------------------------------------
    cbg_frame_if frm ();
    cbg_state_t state_r;
    cbg_state_t state_nxt;
    cbg_width_t width_r;
    logic enable_r;
    logic clk_en_r;
    logic bus_req_r;
    logic dma_grant_r;
    logic slow_meta_r;
    logic slow_sync_r;
    logic slow_prev_r;
    logic aw_full_r;
    logic w_full_r;
    logic [3:0] awaddr_r;
    logic [31:0] wdata_r;
    logic [3:0] wstrb_r;
    logic awready_r;
    logic wready_r;
    logic bvalid_r;
    logic [1:0] bresp_r;
    logic arready_r;
    logic rvalid_r;
    logic [1:0] rresp_r;
    logic [31:0] rdata_r;
    logic wr_fire;
    logic ctrl_wr;
    logic slot_go;
    logic wake_hit;
    logic [31:0] ctrl_word;
    logic [31:0] stat_word;

    // -------------------------------------------------------------------------
    // Slow clock synchroniser and rising-edge tick
    // -------------------------------------------------------------------------
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            slow_meta_r <= 1'b0;
            slow_sync_r <= 1'b0;
            slow_prev_r <= 1'b0;
        end else begin
            slow_meta_r <= slow_32k_clock;
            slow_sync_r <= slow_meta_r;
            slow_prev_r <= slow_sync_r;
        end
    end

    assign frm.slow_tick = slow_sync_r & ~slow_prev_r;
    assign frm.width = width_r;

    cbg_frame u_frame (
        .mclk (mclk),
        .rst_n (rst_n),
        .frm (frm)
    );

    // -------------------------------------------------------------------------
    // Register write decode
    // -------------------------------------------------------------------------
    assign wr_fire = aw_full_r & w_full_r & ~bvalid_r;
    assign ctrl_wr = wr_fire & (awaddr_r == `CBG_CTRL_OFFSET) & wstrb_r[0];

    // -------------------------------------------------------------------------
    // Control register: enable and width
    // -------------------------------------------------------------------------
    // Any interrupt counts, whether or not the core masks it
    assign wake_hit = wake_event & enable_r;

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            enable_r <= `CBG_EN_RESET;
        end else if (ctrl_wr) begin
            enable_r <= wdata_r[`CBG_EN_BIT];
        end else if (wake_hit) begin
            enable_r <= 1'b0;
        end
    end

    // Width is touched by software writes only, never by enable or wake
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            width_r <= `CBG_WIDTH_RESET;
        end else if (ctrl_wr) begin
            width_r <= wdata_r[`CBG_WIDTH_MSB:`CBG_WIDTH_LSB];
        end
    end

    // -------------------------------------------------------------------------
    // Gating state machine
    // -------------------------------------------------------------------------
    // Core owns the clock while gating is off or its slot is running
    assign slot_go = ~enable_r | wake_event | frm.slot_on;

    always_comb begin
        state_nxt = state_r;
        unique case (state_r)
            CBG_RUN: begin
                if (!slot_go) begin
                    state_nxt = CBG_REQ;
                end
            end
            CBG_REQ: begin
                if (slot_go) begin
                    state_nxt = CBG_RUN;
                end else if (core_bus_grant) begin
                    state_nxt = CBG_OFF;
                end
            end
            CBG_OFF: begin
                if (slot_go) begin
                    state_nxt = CBG_REL;
                end
            end
            CBG_REL: begin
                if (!dma_busy) begin
                    state_nxt = CBG_RUN;
                end
            end
        endcase
    end

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            state_r <= CBG_RUN;
        end else begin
            state_r <= state_nxt;
        end
    end

    // -------------------------------------------------------------------------
    // Core clock enable, registered so it moves only on mclk edges
    // -------------------------------------------------------------------------
    // Master clock itself is never gated here; only the core's enable is
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            clk_en_r <= 1'b1;
        end else if (state_nxt == CBG_OFF) begin
            clk_en_r <= 1'b0;
        end else begin
            clk_en_r <= 1'b1;
        end
    end

    // -------------------------------------------------------------------------
    // Bus request to the core
    // -------------------------------------------------------------------------
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            bus_req_r <= 1'b0;
        end else begin
            bus_req_r <= (state_nxt != CBG_RUN);
        end
    end

    // -------------------------------------------------------------------------
    // Bus grant to the DMA controller
    // -------------------------------------------------------------------------
    // Drops on leaving OFF, before the core request is released
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            dma_grant_r <= 1'b0;
        end else begin
            dma_grant_r <= (state_nxt == CBG_OFF);
        end
    end

    assign core_gated_clock_en = clk_en_r;
    assign core_bus_req = bus_req_r;
    assign dma_bus_grant = dma_grant_r;

    // -------------------------------------------------------------------------
    // AXI4-Lite write address and data capture
    // -------------------------------------------------------------------------
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            aw_full_r <= 1'b0;
            awready_r <= 1'b1;
            awaddr_r <= 4'h0;
        end else if (s_axi_awvalid && awready_r) begin
            aw_full_r <= 1'b1;
            awready_r <= 1'b0;
            awaddr_r <= s_axi_awaddr;
        end else if (wr_fire) begin
            aw_full_r <= 1'b0;
        end else if (bvalid_r && s_axi_bready) begin
            awready_r <= 1'b1;
        end
    end

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            w_full_r <= 1'b0;
            wready_r <= 1'b1;
            wdata_r <= 32'h0000_0000;
            wstrb_r <= 4'h0;
        end else if (s_axi_wvalid && wready_r) begin
            w_full_r <= 1'b1;
            wready_r <= 1'b0;
            wdata_r <= s_axi_wdata;
            wstrb_r <= s_axi_wstrb;
        end else if (wr_fire) begin
            w_full_r <= 1'b0;
        end else if (bvalid_r && s_axi_bready) begin
            wready_r <= 1'b1;
        end
    end

    // -------------------------------------------------------------------------
    // AXI4-Lite write response
    // -------------------------------------------------------------------------
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            bvalid_r <= 1'b0;
            bresp_r <= `CBG_RESP_OKAY;
        end else if (wr_fire) begin
            bvalid_r <= 1'b1;
            if (awaddr_r == `CBG_CTRL_OFFSET || awaddr_r == `CBG_STAT_OFFSET) begin
                bresp_r <= `CBG_RESP_OKAY;
            end else begin
                bresp_r <= `CBG_RESP_DECERR;
            end
        end else if (bvalid_r && s_axi_bready) begin
            bvalid_r <= 1'b0;
        end
    end

    assign s_axi_awready = awready_r;
    assign s_axi_wready = wready_r;
    assign s_axi_bvalid = bvalid_r;
    assign s_axi_bresp = bresp_r;

    // -------------------------------------------------------------------------
    // Read data words
    // -------------------------------------------------------------------------
    // Reserved bits 6..5 always read zero
    always_comb begin
        ctrl_word = 32'h0000_0000;
        ctrl_word[`CBG_EN_BIT] = enable_r;
        ctrl_word[`CBG_WIDTH_MSB:`CBG_WIDTH_LSB] = width_r;
    end

    always_comb begin
        stat_word = 32'h0000_0000;
        stat_word[`CBG_ST_POS_MSB:`CBG_ST_POS_LSB] = frm.frame_pos;
        stat_word[`CBG_ST_SLOT_BIT] = frm.slot_on;
        stat_word[`CBG_ST_REQ_BIT] = bus_req_r;
        stat_word[`CBG_ST_CLK_BIT] = clk_en_r;
        stat_word[`CBG_ST_DMA_BIT] = dma_grant_r;
        stat_word[`CBG_ST_EN_BIT] = enable_r;
    end

    // -------------------------------------------------------------------------
    // AXI4-Lite read channel
    // -------------------------------------------------------------------------
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            arready_r <= 1'b1;
            rvalid_r <= 1'b0;
            rresp_r <= `CBG_RESP_OKAY;
            rdata_r <= 32'h0000_0000;
        end else if (s_axi_arvalid && arready_r) begin
            arready_r <= 1'b0;
            rvalid_r <= 1'b1;
            if (s_axi_araddr == `CBG_CTRL_OFFSET) begin
                rdata_r <= ctrl_word;
                rresp_r <= `CBG_RESP_OKAY;
            end else if (s_axi_araddr == `CBG_STAT_OFFSET) begin
                rdata_r <= stat_word;
                rresp_r <= `CBG_RESP_OKAY;
            end else begin
                rdata_r <= 32'h0000_0000;
                rresp_r <= `CBG_RESP_DECERR;
            end
        end else if (rvalid_r && s_axi_rready) begin
            rvalid_r <= 1'b0;
            arready_r <= 1'b1;
        end
    end

    assign s_axi_arready = arready_r;
    assign s_axi_rvalid = rvalid_r;
    assign s_axi_rresp = rresp_r;
    assign s_axi_rdata = rdata_r;

endmodule // cbg_top

`default_nettype wire

/* File: pkg/cbg_map.svh */
// Register offsets, field positions, reset values and timing counts
`ifndef CBG_MAP_SVH
`define CBG_MAP_SVH

// -----------------------------------------------------------------------------
// Register map (byte addresses)
// -----------------------------------------------------------------------------
`define CBG_CTRL_OFFSET 4'h0
`define CBG_STAT_OFFSET 4'h4
`define CBG_ADDR_BITS 4

// -----------------------------------------------------------------------------
// Control register fields
// -----------------------------------------------------------------------------
`define CBG_EN_BIT 7
`define CBG_WIDTH_MSB 4
`define CBG_WIDTH_LSB 0
`define CBG_WIDTH_RESET 5'h1f
`define CBG_EN_RESET 1'b0

// -----------------------------------------------------------------------------
// Status register fields
// -----------------------------------------------------------------------------
`define CBG_ST_POS_LSB 0
`define CBG_ST_POS_MSB 4
`define CBG_ST_SLOT_BIT 8
`define CBG_ST_REQ_BIT 9
`define CBG_ST_CLK_BIT 10
`define CBG_ST_DMA_BIT 11
`define CBG_ST_EN_BIT 12

// -----------------------------------------------------------------------------
// Frame timing
// -----------------------------------------------------------------------------
`define CBG_FRAME_PERIODS 5'h1f
`define CBG_POS_LAST 5'h1e

// -----------------------------------------------------------------------------
// Bus answers
// -----------------------------------------------------------------------------
`define CBG_RESP_OKAY 2'h0
`define CBG_RESP_DECERR 2'h3

`endif

/* File: pkg/cbg_pkg.sv */
// Types shared by the burst gating modules
package cbg_pkg;

    typedef enum logic [1:0] {
        CBG_RUN,
        CBG_REQ,
        CBG_OFF,
        CBG_REL
    } cbg_state_t;

    typedef logic [4:0] cbg_width_t;

endpackage

/* File: pkg/cbg_frame_if.sv */
// Carrier between the control core and the frame timer
`timescale 1ns/1ps
`default_nettype none

interface cbg_frame_if;
    import cbg_pkg::*;
    logic slow_tick;
    cbg_width_t width;
    cbg_width_t frame_pos;
    logic slot_on;

    modport timer (input slow_tick, input width, output frame_pos, output slot_on);
    modport ctrl (output slow_tick, output width, input frame_pos, input slot_on);
endinterface

`default_nettype wire

/* File: hw/cbg_frame.sv */
// Frame timer: 31 slow-clock periods per frame, on-slot from width
`timescale 1ns/1ps
`default_nettype none
`include "cbg_map.svh"

module cbg_frame
    import cbg_pkg::*;
(
    input wire logic mclk, // System master clock
    input wire logic rst_n, // Synchronous reset, active low
    cbg_frame_if.timer frm // Tick in, position and slot out
);

    cbg_width_t pos_r;

    // -------------------------------------------------------------------------
    // Frame position, wraps after the last slow period
    // -------------------------------------------------------------------------
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            pos_r <= 5'h00;
        end else if (frm.slow_tick) begin
            if (pos_r == `CBG_POS_LAST) begin
                pos_r <= 5'h00;
            end else begin
                pos_r <= pos_r + 5'h01;
            end
        end
    end

    // Slot holds while position is below width; 31 never ends, 0 never starts
    assign frm.slot_on = (pos_r < frm.width);
    assign frm.frame_pos = pos_r;

endmodule // cbg_frame

`default_nettype wire

/* File: sim/cbg_props.sv */
// Port-level checks for the core clock burst gating block
`timescale 1ns/1ps
`default_nettype none

module cbg_props (
    input wire logic mclk, // Master clock
    input wire logic rst_n, // Reset, active low
    input wire logic wake_event, // Wake input
    input wire logic core_bus_grant, // Core released bus
    input wire logic dma_busy, // DMA access running
    input wire logic core_gated_clock_en, // Core clock enable
    input wire logic core_bus_req, // Bus request to core
    input wire logic dma_bus_grant, // Grant to DMA
    input wire logic s_axi_arvalid, // Read address valid
    input wire logic s_axi_arready, // Read address ready
    input wire logic [31:0] s_axi_rdata, // Read data
    input wire logic s_axi_rvalid, // Read valid
    input wire logic s_axi_rready, // Read ready
    input wire logic [1:0] s_axi_bresp, // Write response
    input wire logic s_axi_bvalid, // Write response valid
    input wire logic s_axi_bready // Write response ready
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n);

    sequence s_req_granted;
        $past(core_bus_req) && $past(core_bus_grant);
    endsequence
    sequence s_off;
        !core_gated_clock_en && dma_bus_grant;
    endsequence

    req_before_off_a: assert property (
        $fell(core_gated_clock_en) |-> s_req_granted ##0 s_off)
        else $error("core clock stopped without granted request");
    grant_wait_a: assert property (
        core_bus_req && !core_bus_grant && core_gated_clock_en |=> core_gated_clock_en)
        else $error("core clock stopped before grant");
    grant_pair_a: assert property (
        core_gated_clock_en == !dma_bus_grant)
        else $error("dma grant and core clock disagree");
    dma_after_grant_a: assert property (
        $rose(dma_bus_grant) |-> $past(core_bus_grant) && core_bus_req)
        else $error("dma grant without core release");
    req_held_a: assert property (
        dma_bus_grant |-> core_bus_req)
        else $error("core request dropped while dma owns bus");
    wake_restore_a: assert property (
        s_off ##0 wake_event |=> core_gated_clock_en && !dma_bus_grant)
        else $error("wake did not restore core clock");
    dma_priority_a: assert property (
        core_bus_req && dma_busy && !dma_bus_grant && core_gated_clock_en |=> core_bus_req)
        else $error("core took bus during dma access");
    reset_state_a: assert property (
        $rose(rst_n) |-> core_gated_clock_en && !core_bus_req && !dma_bus_grant)
        else $error("bad state after reset");
    read_answer_a: assert property (
        s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read not answered next cycle");
    rdata_hold_a: assert property (
        s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data not held");
    bresp_hold_a: assert property (
        s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response not held");
endmodule // cbg_props

bind cbg_top cbg_props u_props (.mclk, .rst_n, .wake_event, .core_bus_grant, .dma_busy,
    .core_gated_clock_en, .core_bus_req, .dma_bus_grant, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rvalid, .s_axi_rready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready);

`default_nettype wire

/* File: sim/cbg_bus_partner.sv */
// Model of the processor core and DMA controller sharing the bus
`timescale 1ns/1ps
`default_nettype none

module cbg_bus_partner (
    input wire logic mclk, // Master clock
    input wire logic rst_n, // Reset, active low
    input wire logic [1:0] grant_dly, // Core release delay
    input wire logic core_bus_req, // Request from gating block
    input wire logic dma_bus_grant, // Grant to DMA
    output logic core_bus_grant, // Core released bus
    output logic dma_busy // DMA access running
);
    logic [1:0] wait_r;
    logic [2:0] len_r;

    // Core gives up the bus after a delay, takes it back when request drops
    always_ff @(posedge mclk) begin
        if (!rst_n || !core_bus_req) begin
            wait_r <= 2'h0;
            core_bus_grant <= 1'b0;
        end else if (wait_r >= grant_dly) begin
            core_bus_grant <= 1'b1;
        end else begin
            wait_r <= wait_r + 2'h1;
        end
    end

    // DMA starts only when granted and always finishes an access
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            dma_busy <= 1'b0;
            len_r <= 3'h0;
        end else if (dma_busy) begin
            len_r <= len_r + 3'h1;
            if (len_r == 3'h5) begin
                dma_busy <= 1'b0;
                len_r <= 3'h0;
            end
        end else if (dma_bus_grant) begin
            dma_busy <= 1'b1;
        end
    end
endmodule // cbg_bus_partner

`default_nettype wire

/* File: sim/cbg_top_tb_top.sv */
// Self-checking bench for the core clock burst gating block
`timescale 1ns/1ps
`default_nettype none
`include "cbg_map.svh"

module cbg_top_tb_top;
    localparam int SLOW_P = 20;
    localparam int FRAME = 31 * SLOW_P;
    logic mclk, rst_n, slow_clk, wake_event, core_bus_grant, dma_busy;
    logic core_gated_clock_en, core_bus_req, dma_bus_grant;
    logic [1:0] grant_dly, bresp, rresp;
    logic [3:0] awaddr, araddr, wstrb;
    logic [31:0] wdata, rdata;
    logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
    logic [7:0] ctrl_m;
    logic [7:0] wtab [7] = '{8'h9f, 8'h80, 8'h81, 8'h83, 8'h9e, 8'h00, 8'h80};
    int n_fail, n_compared, seed;

    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end
    // Sped-up slow clock, each edge 2 ns before an mclk rising edge
    initial begin
        slow_clk = 1'b0;
        #3;
        forever #(SLOW_P * 5) slow_clk = ~slow_clk;
    end

    cbg_top DUT (.mclk(mclk), .rst_n(rst_n), .slow_32k_clock(slow_clk),
        .wake_event(wake_event), .core_bus_grant(core_bus_grant), .dma_busy(dma_busy),
        .core_gated_clock_en(core_gated_clock_en), .core_bus_req(core_bus_req),
        .dma_bus_grant(dma_bus_grant), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));
    cbg_bus_partner u_partner (.mclk(mclk), .rst_n(rst_n), .grant_dly(grant_dly),
        .core_bus_req(core_bus_req), .dma_bus_grant(dma_bus_grant),
        .core_bus_grant(core_bus_grant), .dma_busy(dma_busy));

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            n_fail++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic tally_and_finish;
        $display("compared %0d mismatches %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    task automatic axi_wr(input logic [3:0] a, input logic [31:0] d, input logic [3:0] s);
        logic done;
        done = 1'b0;
        @(posedge mclk);
        awaddr <= a;
        wdata <= d;
        wstrb <= s;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        while (!done) begin
            @(posedge mclk);
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
            if (bvalid) begin
                done = 1'b1;
                bready <= 1'b0;
                check(bresp, (a == `CBG_CTRL_OFFSET || a == `CBG_STAT_OFFSET) ?
                    `CBG_RESP_OKAY : `CBG_RESP_DECERR);
            end
        end
        if (a == `CBG_CTRL_OFFSET && s[0]) ctrl_m = d[7:0] & 8'h9f;
    endtask

    task automatic read_chk(input logic [3:0] a, input logic [31:0] exp,
        input logic [31:0] msk = 32'hffff_ffff);
        logic done;
        done = 1'b0;
        @(posedge mclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        while (!done) begin
            @(posedge mclk);
            if (arvalid && arready) arvalid <= 1'b0;
            if (rvalid) begin
                done = 1'b1;
                rready <= 1'b0;
                check(rdata & msk, exp);
                check(rresp, (a == `CBG_CTRL_OFFSET || a == `CBG_STAT_OFFSET) ?
                    `CBG_RESP_OKAY : `CBG_RESP_DECERR);
            end
        end
    endtask

    // Settle one frame, then count enabled core clock cycles over the next
    task automatic duty(input logic [7:0] c);
        int n;
        n = 0;
        grant_dly <= 2'($random(seed));
        axi_wr(`CBG_CTRL_OFFSET, {24'h0, c}, 4'hf);
        repeat (FRAME) @(posedge mclk);
        repeat (FRAME) begin
            @(posedge mclk);
            if (core_gated_clock_en === 1'b1) n++;
        end
        check((n + SLOW_P / 2) / SLOW_P, ctrl_m[7] ? ctrl_m[4:0] : 31);
        read_chk(`CBG_CTRL_OFFSET, {24'h0, ctrl_m});
    endtask

    task automatic wake;
        @(posedge mclk);
        wake_event <= 1'b1;
        @(posedge mclk);
        wake_event <= 1'b0;
        ctrl_m = ctrl_m & 8'h1f;
        @(posedge mclk);
        #1;
        check(core_gated_clock_en, 1'b1);
        read_chk(`CBG_CTRL_OFFSET, {24'h0, ctrl_m});
    endtask

    initial begin
        seed = 32'h686a2111;
        {rst_n, wake_event, awvalid, wvalid, bready, arvalid, rready} = '0;
        {awaddr, araddr, wstrb, wdata, grant_dly} = '0;
        ctrl_m = {`CBG_EN_RESET, 2'h0, `CBG_WIDTH_RESET};
        repeat (16) @(posedge mclk);
        rst_n <= 1'b1;
        read_chk(`CBG_CTRL_OFFSET, 32'h1f);
        check(core_gated_clock_en, 1'b1);
        read_chk(4'h8, 32'h0);
        axi_wr(4'h8, 32'h9f, 4'hf);
        axi_wr(`CBG_STAT_OFFSET, 32'h9f, 4'hf);
        axi_wr(`CBG_CTRL_OFFSET, 32'h83, 4'he);
        read_chk(`CBG_CTRL_OFFSET, {24'h0, ctrl_m});
        $display("test register map done");
        wtab[6] = 8'h80 | (8'($random(seed)) & 8'h1f);
        foreach (wtab[i]) duty(wtab[i]);
        $display("test burst widths done");
        duty(8'h80);
        check(dma_bus_grant, 1'b1);
        check(core_gated_clock_en, 1'b0);
        // Status while idle: request and dma grant up, clock and slot down
        read_chk(`CBG_STAT_OFFSET, 32'h0000_1a00, 32'h0000_1f00);
        wake();
        axi_wr(`CBG_CTRL_OFFSET, 32'h85, 4'hf);
        repeat (($random(seed) & 32'h1ff) + 32) @(posedge mclk);
        wake();
        $display("test wake done");
        tally_and_finish();
    end

    initial begin
        repeat (60000) @(posedge mclk);
        n_fail++;
        tally_and_finish();
    end
endmodule // cbg_top_tb_top

`default_nettype wire
